// ### src/peak_signal_monitor.sv
// Peak signal monitor with register access and sample-embedded result serializer
// Notes on behaviour
// [RULE1] One global 24-bit period times measurements
// [RULE2] Track magnitude only; report 13-bit peak
// [RULE3] Period counts converter output samples
// [RULE4] Control register bit 1 starts detection
// [RULE5] Software writes period before enabling
// [RULE6] Enable loads timer; decrement every cycle
// [RULE7] Keep larger of sample and stored peak
// [RULE8] Period start seeds peak with current sample
// [RULE9] At count 1 copy peak to holding
// [RULE10] Then reload timer and reseed peak
// [RULE11] Embed only when link enable bits set
// [RULE12] Up to three control bits, MSB first; code embeds only the monitor bit at word bit 1, bit 0 zero when cs_num >= 2
// [RULE13] Software programs link config registers
// [RULE14] 25-bit frame, five 5-bit subframes, MSB first
// [RULE15] Receiver deserializes and checks start bits
// [RULE16] Sample bits 13..6, then 5..0 plus tails
// [RULE17] Tails are zeros or pseudorandom
// [RULE18] Control bits sit below sample LSB
// [RULE19] One frame bit per sample, whole frames
// [RULE20] Holding keeps value; zero after reset
`timescale 1ns/1ns
`include "peak_monitor_regs.svh"
module peak_signal_monitor #(
    parameter int SAMPLE_W = 14
) (
    // Clock and reset
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    // Register access
    input  wire peak_monitor_pkg::reg_req_t    reg_req,
    output logic [7:0]                         reg_rdata,
    // Decimated sample stream
    input  wire logic [SAMPLE_W-1:0]           sample_in,
    // Link sample word and held peak
    output logic [15:0]                        link_word,
    output logic [12:0]                        peak_hold
);
    peak_monitor_pkg::mon_state_t st_ff;
    peak_monitor_pkg::mon_state_t nxt_st;

    logic [SAMPLE_W-1:0] abs_val;
    logic [12:0]         mag;
    logic                embed_on;
    logic [1:0]          cs_num;
    logic                mon_bit;
    logic [1:0]          low_bits;
    logic [1:0]          tail_bits;
    logic                prbs_fb;

    always_comb begin
        abs_val = sample_in[SAMPLE_W-1] ? (~sample_in + 1'b1) : sample_in;
        if (abs_val[SAMPLE_W-1] || (abs_val[SAMPLE_W-2:0] > SAMPLE_W'(`PEAK_MAX))) begin
            mag = `PEAK_MAX; // RULE2
        end else begin
            mag = abs_val[12:0]; // RULE2
        end
    end

    always_comb begin
        embed_on  = (st_ff.link_en_a[1:0] == 2'b11)
                    && st_ff.link_en_b[`MON_LINK_EN_B_BIT]; // RULE11
        cs_num    = st_ff.link_cfg_c[`LINK_CS_LSB +: 2];
        mon_bit   = embed_on && (st_ff.frame_cnt != 5'd0) && st_ff.frame[24]; // RULE14
        prbs_fb   = st_ff.prbs[14] ^ st_ff.prbs[13];
        tail_bits = st_ff.link_cfg_a[`LINK_TAIL_PRBS_BIT] ? st_ff.prbs[1:0] : 2'b00; // RULE17
        if (embed_on && (cs_num != 2'd0)) begin
            low_bits = (cs_num == 2'd1) ? {mon_bit, tail_bits[0]} : {mon_bit, 1'b0}; // RULE12 RULE18
        end else begin
            low_bits = tail_bits; // RULE17
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // Register writes
        if (reg_req.wr) begin
            if (reg_req.addr == `MON_CONTROL_ADDR) begin
                nxt_st.control = reg_req.wdata;
            end else if (reg_req.addr == `MON_LINK_EN_A_ADDR) begin
                nxt_st.link_en_a = reg_req.wdata;
            end else if (reg_req.addr == `MON_LINK_EN_B_ADDR) begin
                nxt_st.link_en_b = reg_req.wdata;
            end else if (reg_req.addr == `MON_PERIOD_0_ADDR) begin
                nxt_st.period[7:0] = reg_req.wdata; // RULE1
            end else if (reg_req.addr == `MON_PERIOD_1_ADDR) begin
                nxt_st.period[15:8] = reg_req.wdata;
            end else if (reg_req.addr == `MON_PERIOD_2_ADDR) begin
                nxt_st.period[23:16] = reg_req.wdata;
            end else if (reg_req.addr == `LINK_CONFIG_A_ADDR) begin
                nxt_st.link_cfg_a = reg_req.wdata;
            end else if (reg_req.addr == `LINK_CONFIG_B_ADDR) begin
                nxt_st.link_cfg_b = reg_req.wdata;
            end else if (reg_req.addr == `LINK_CONFIG_C_ADDR) begin
                nxt_st.link_cfg_c = reg_req.wdata;
            end
        end
        // Register reads
        if (reg_req.rd) begin
            if (reg_req.addr == `MON_CONTROL_ADDR) begin
                nxt_st.rdata = st_ff.control;
            end else if (reg_req.addr == `MON_LINK_EN_A_ADDR) begin
                nxt_st.rdata = st_ff.link_en_a;
            end else if (reg_req.addr == `MON_LINK_EN_B_ADDR) begin
                nxt_st.rdata = st_ff.link_en_b;
            end else if (reg_req.addr == `MON_PERIOD_0_ADDR) begin
                nxt_st.rdata = st_ff.period[7:0];
            end else if (reg_req.addr == `MON_PERIOD_1_ADDR) begin
                nxt_st.rdata = st_ff.period[15:8];
            end else if (reg_req.addr == `MON_PERIOD_2_ADDR) begin
                nxt_st.rdata = st_ff.period[23:16];
            end else if (reg_req.addr == `MON_HOLD_LO_ADDR) begin
                nxt_st.rdata = st_ff.hold[7:0]; // RULE9
            end else if (reg_req.addr == `MON_HOLD_HI_ADDR) begin
                nxt_st.rdata = {3'b000, st_ff.hold[12:8]};
            end else if (reg_req.addr == `LINK_CONFIG_A_ADDR) begin
                nxt_st.rdata = st_ff.link_cfg_a;
            end else if (reg_req.addr == `LINK_CONFIG_B_ADDR) begin
                nxt_st.rdata = st_ff.link_cfg_b;
            end else if (reg_req.addr == `LINK_CONFIG_C_ADDR) begin
                nxt_st.rdata = st_ff.link_cfg_c;
            end else begin
                nxt_st.rdata = 8'h00;
            end
        end
        // Peak detector
        nxt_st.enabled = st_ff.control[`MON_PEAK_EN_BIT]; // RULE4
        if (!st_ff.control[`MON_PEAK_EN_BIT]) begin
            nxt_st.timer = 24'h000000;
        end else if (!st_ff.enabled) begin
            nxt_st.timer = st_ff.period; // RULE5 RULE6
            nxt_st.peak  = mag; // RULE8
        end else if (st_ff.timer <= 24'h000001) begin
            nxt_st.hold  = (mag > st_ff.peak) ? mag : st_ff.peak; // RULE9 RULE20
            nxt_st.timer = st_ff.period; // RULE10
            nxt_st.peak  = 13'h0000; // RULE10
        end else begin
            nxt_st.timer = st_ff.timer - 24'h000001; // RULE3 RULE6
            if (st_ff.timer == st_ff.period) begin
                nxt_st.peak = (st_ff.peak == 13'h0000) ? mag
                            : ((mag > st_ff.peak) ? mag : st_ff.peak); // RULE8 RULE7
            end else begin
                nxt_st.peak = (mag > st_ff.peak) ? mag : st_ff.peak; // RULE7
            end
        end
        if (st_ff.enabled && st_ff.timer <= 24'h000001 && st_ff.control[`MON_PEAK_EN_BIT]) begin
            nxt_st.peak = mag; // RULE10
        end
        // Frame serializer
        if (embed_on && (cs_num != 2'd0)) begin
            if (st_ff.frame_cnt <= 5'd1) begin
                nxt_st.frame     = {1'b1, 4'h0, 1'b1, 3'b000, st_ff.hold[12],
                                    1'b1, st_ff.hold[11:8], 1'b1, st_ff.hold[7:4],
                                    1'b1, st_ff.hold[3:0]}; // RULE14 RULE19
                nxt_st.frame_cnt = `FRAME_BITS;
            end else begin
                nxt_st.frame     = {st_ff.frame[23:0], 1'b0}; // RULE19
                nxt_st.frame_cnt = st_ff.frame_cnt - 5'd1;
            end
        end else begin
            nxt_st.frame_cnt = 5'd0;
        end
        nxt_st.prbs = {st_ff.prbs[13:0], prbs_fb};
        nxt_st.word = {sample_in, low_bits}; // RULE16 RULE18
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{control: `REG8_RESET, link_en_a: `REG8_RESET, link_en_b: `REG8_RESET,
                       link_cfg_a: `REG8_RESET, link_cfg_b: `REG8_RESET,
                       link_cfg_c: `REG8_RESET, period: `PERIOD_RESET, enabled: 1'b0,
                       timer: 24'h000000, peak: 13'h0000, hold: 13'h0000,
                       frame: 25'h0000000, frame_cnt: 5'd0, prbs: `PRBS_SEED,
                       word: 16'h0000, rdata: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata = st_ff.rdata;
    assign link_word = st_ff.word;
    assign peak_hold = st_ff.hold;
endmodule

// ### src/peak_monitor_regs.svh
// Register offsets, field positions, reset values and counts for the peak signal monitor
`ifndef PEAK_MONITOR_REGS_SVH
`define PEAK_MONITOR_REGS_SVH
`define MON_CONTROL_ADDR      12'h270
`define MON_LINK_EN_A_ADDR    12'h279
`define MON_LINK_EN_B_ADDR    12'h27A
`define MON_PERIOD_0_ADDR     12'h280
`define MON_PERIOD_1_ADDR     12'h281
`define MON_PERIOD_2_ADDR     12'h282
`define MON_HOLD_LO_ADDR      12'h284
`define MON_HOLD_HI_ADDR      12'h285
`define LINK_CONFIG_A_ADDR    12'h559
`define LINK_CONFIG_B_ADDR    12'h55A
`define LINK_CONFIG_C_ADDR    12'h58F
`define MON_PEAK_EN_BIT       1
`define MON_LINK_EN_B_BIT     1
`define LINK_TAIL_PRBS_BIT    0
`define LINK_CS_LSB           6
`define REG8_RESET            8'h00
`define PERIOD_RESET          24'h000000
`define PRBS_SEED             15'h7FFF
`define FRAME_BITS            5'd25
`define SUBFRAME_BITS         3'd5
`define PEAK_MAX              13'h1FFF
`endif

// ### src/peak_monitor_pkg.sv
// Types for the peak signal monitor
package peak_monitor_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [11:0] addr;
        logic [7:0]  wdata;
    } reg_req_t;

    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  link_en_a;
        logic [7:0]  link_en_b;
        logic [7:0]  link_cfg_a;
        logic [7:0]  link_cfg_b;
        logic [7:0]  link_cfg_c;
        logic [23:0] period;
        logic        enabled;
        logic [23:0] timer;
        logic [12:0] peak;
        logic [12:0] hold;
        logic [24:0] frame;
        logic [4:0]  frame_cnt;
        logic [14:0] prbs;
        logic [15:0] word;
        logic [7:0]  rdata;
    } mon_state_t;
endpackage

// ### tb/peak_monitor_chk.sv
// Port checks for the peak signal monitor
`timescale 1ns/1ns
`include "peak_monitor_regs.svh"
module peak_monitor_chk #(parameter int SAMPLE_W = 14) (
    // Clock, reset and registers
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire peak_monitor_pkg::reg_req_t reg_req,
    input wire logic [7:0]                 reg_rdata,
    // Stream
    input wire logic [SAMPLE_W-1:0]        sample_in,
    input wire logic [15:0]                link_word,
    input wire logic [12:0]                peak_hold
);
    logic [7:0]  ena_ff, enb_ff, cfa_ff, cfc_ff;
    logic [12:0] mag;
    logic        link_on, zero_tail, cs_wide;
    assign mag = sample_in == 14'h2000 ? 13'h1FFF : 13'(sample_in[13] ? -sample_in : sample_in);
    assign link_on = ena_ff[1:0] == 2'h3 && enb_ff[1] && cfc_ff[7:6] != 2'h0;
    assign zero_tail = !link_on && !cfa_ff[0];
    assign cs_wide = link_on && cfc_ff[7];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {ena_ff, enb_ff, cfa_ff, cfc_ff} <= '0;
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                `MON_LINK_EN_A_ADDR: ena_ff <= reg_req.wdata;
                `MON_LINK_EN_B_ADDR: enb_ff <= reg_req.wdata;
                `LINK_CONFIG_A_ADDR: cfa_ff <= reg_req.wdata;
                `LINK_CONFIG_C_ADDR: cfc_ff <= reg_req.wdata;
                default: ;
            endcase
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    AST_SAMPLE_BITS: assert property (!$past(rst) |-> link_word[15:2] == $past(sample_in))
        else $error("sample bits misplaced");
    AST_HOLD_RESET: assert property ($past(rst) |-> peak_hold == 13'h0000)
        else $error("hold not clear after reset");
    AST_HOLD_PEAK: assert property ($changed(peak_hold) |-> peak_hold >= $past(mag))
        else $error("hold below sample magnitude");
    AST_READ_LO: assert property (reg_req.rd && reg_req.addr == `MON_HOLD_LO_ADDR
        |=> reg_rdata == 8'($past(peak_hold))) else $error("hold low byte read");
    AST_READ_HI: assert property (reg_req.rd && reg_req.addr == `MON_HOLD_HI_ADDR
        |=> reg_rdata == 8'($past(peak_hold) >> 8)) else $error("hold high byte read");
    AST_RDATA_STANDS: assert property (!reg_req.rd |=> $stable(reg_rdata))
        else $error("read data moved");
    AST_ZERO_TAIL: assert property ($past(zero_tail) |-> link_word[1:0] == 2'h0)
        else $error("tail bits not zero");
    AST_CS_LOW: assert property ($past(cs_wide) |-> link_word[0] == 1'b0)
        else $error("low control bit not zero");
endmodule
bind peak_signal_monitor peak_monitor_chk #(.SAMPLE_W(SAMPLE_W)) i_peak_monitor_chk (
    .sys_clk(sys_clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sample_in(sample_in), .link_word(link_word), .peak_hold(peak_hold));

// ### tb/link_frame_rx.sv
// Receiving logic that hunts and decodes monitor frames
`timescale 1ns/1ns
module link_frame_rx (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    rst,
    // Link word and decoded frame
    input wire logic [15:0] link_word,
    output logic [12:0]     frame_val,
    output logic            frame_ok
);
    logic [24:0] sr_ff, nxt_sr;
    logic [4:0]  skip_ff;
    logic        hit;
    assign nxt_sr = {sr_ff[23:0], link_word[1]};
    // Start bits and fixed zeros validate a frame
    assign hit = skip_ff == 5'h00 && nxt_sr[24:16] == 9'h108 && nxt_sr[14] && nxt_sr[9] && nxt_sr[4];
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            {sr_ff, skip_ff, frame_ok, frame_val} <= '0;
        end else begin
            sr_ff <= nxt_sr;
            frame_ok <= hit;
            skip_ff <= hit ? 5'h18 : skip_ff - 5'(skip_ff != 5'h00);
            if (hit) frame_val <= {nxt_sr[15], nxt_sr[13:10], nxt_sr[8:5], nxt_sr[3:0]};
        end
    end
endmodule

// ### tb/peak_signal_monitor_bench.sv
// Bench for the peak signal monitor
`timescale 1ns/1ns
`include "peak_monitor_regs.svh"
module peak_signal_monitor_bench;
    logic                       sys_clk = 0, rst = 1, ramp = 0, rd_pend = 0, frame_ok;
    peak_monitor_pkg::reg_req_t reg_req = '0;
    logic [7:0]                 reg_rdata;
    logic [13:0]                sample_in = '0, const_v = '0, tbl [4];
    logic [15:0]                link_word, rd_q [$], fr_q [$], per_q [$];
    logic [12:0]                peak_hold, frame_val, last_h = '0, exps [4];
    int                         miscompares = 0, tests_run = 0;
    peak_signal_monitor #(.SAMPLE_W(14)) i_peak_signal_monitor (.sys_clk(sys_clk), .rst(rst),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_in(sample_in),
        .link_word(link_word), .peak_hold(peak_hold));
    link_frame_rx i_link_frame_rx (.sys_clk(sys_clk), .rst(rst), .link_word(link_word),
        .frame_val(frame_val), .frame_ok(frame_ok));
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge sys_clk);
        reg_req <= '0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
        rd_q.push_back(e);
        acc(1'b0, a, 8'h00);
    endtask
    task automatic drain();
        for (int i = 0; i < 300 && rd_q.size() + fr_q.size() + per_q.size() > 0; i++)
            @(posedge sys_clk);
        if (rd_q.size() + fr_q.size() + per_q.size() > 0) begin
            miscompares++;
            print_verdict();
        end
    endtask
    always @(posedge sys_clk) begin
        sample_in <= ramp ? sample_in + 14'h0001 : const_v;
        rd_pend <= reg_req.rd;
        last_h <= peak_hold;
        if (rd_pend && rd_q.size() > 0) chk(16'(reg_rdata), rd_q.pop_front());
        if (frame_ok && fr_q.size() > 0) chk(16'(frame_val), fr_q.pop_front());
        if (peak_hold !== last_h && per_q.size() > 0)
            chk(16'(peak_hold - last_h), per_q.pop_front());
    end
    initial begin
        void'($urandom(32'h9000));
        tbl = '{14'h2000, 14'h3000, 14'(2 + $urandom % 4000), 14'h3FFF};
        exps = '{13'h1FFF, 13'h1000, tbl[2][12:0], 13'h0001};
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        acc(1'b1, `MON_PERIOD_0_ADDR, 8'h05);
        acc(1'b1, `MON_PERIOD_1_ADDR, 8'h00);
        acc(1'b1, `MON_PERIOD_2_ADDR, 8'h00);
        acc(1'b1, `MON_CONTROL_ADDR, 8'h02);
        rd_chk(`MON_CONTROL_ADDR, 16'h0002);
        rd_chk(12'h100, 16'h0000);
        ramp <= 1'b1;
        repeat (20) @(posedge sys_clk);
        per_q = '{16'h0005, 16'h0005, 16'h0005};
        drain();
        ramp <= 1'b0;
        acc(1'b1, `LINK_CONFIG_A_ADDR, 8'h00);
        acc(1'b1, `LINK_CONFIG_B_ADDR, 8'h00);
        acc(1'b1, `LINK_CONFIG_C_ADDR, 8'h40);
        acc(1'b1, `MON_LINK_EN_A_ADDR, 8'h03);
        acc(1'b1, `MON_LINK_EN_B_ADDR, 8'h02);
        for (int i = 0; i < 4; i++) begin
            const_v <= tbl[i];
            repeat (60) @(posedge sys_clk);
            fr_q.push_back(16'(exps[i]));
            rd_chk(`MON_HOLD_LO_ADDR, 16'(exps[i][7:0]));
            rd_chk(`MON_HOLD_HI_ADDR, 16'(exps[i][12:8]));
            drain();
        end
        acc(1'b1, `MON_HOLD_LO_ADDR, 8'hFF);
        rd_chk(`MON_HOLD_LO_ADDR, 16'h0001);
        acc(1'b1, `LINK_CONFIG_C_ADDR, 8'h80);
        acc(1'b1, `MON_LINK_EN_A_ADDR, 8'h00);
        acc(1'b1, `LINK_CONFIG_A_ADDR, 8'h01);
        repeat (30) @(posedge sys_clk);
        drain();
        print_verdict();
    end
endmodule
